// ==== shared/uart_pkg.sv ====
`default_nettype none
package uart_pkg;
  // Byte offsets of the register words
  localparam logic [5:0] OFS_DATA     = 6'h00; // receive_buffer read, transmit_holding write
  localparam logic [5:0] OFS_INT_EN   = 6'h04;
  localparam logic [5:0] OFS_INT_PEND = 6'h08;
  localparam logic [5:0] OFS_FIFO_CTL = 6'h0c;
  localparam logic [5:0] OFS_MLC      = 6'h10; // modem_line_control
  localparam logic [5:0] OFS_LSR      = 6'h14; // line status
  localparam logic [5:0] OFS_MLS      = 6'h18; // modem_line_status
  localparam logic [5:0] OFS_SCRATCH  = 6'h1c;
  localparam logic [5:0] OFS_DIV_LO   = 6'h20;
  localparam logic [5:0] OFS_DIV_HI   = 6'h24;

  // Field positions
  localparam int IE_RX_POS     = 0;
  localparam int IE_HOLD_POS   = 1;
  localparam int IE_MODEM_POS  = 3;
  localparam int FC_MODE_POS   = 0;
  localparam int FC_RXCLR_POS  = 1;
  localparam int FC_TXCLR_POS  = 2;
  localparam int MC_LOOP_POS   = 4;
  localparam int LS_READY_POS  = 0;
  localparam int LS_OVERRUN_POS = 1;
  localparam int LS_HOLD_POS   = 5;
  localparam int LS_TEMT_POS   = 6;

  // Values after reset
  localparam logic [7:0]  DIV_LO_RESET  = 8'h01;
  localparam logic [7:0]  DIV_HI_RESET  = 8'h00;
  localparam logic [3:0]  INT_EN_RESET  = 4'h0;
  localparam logic [7:0]  FIFO_CTL_RESET = 8'h00;
  localparam logic [4:0]  MLC_RESET     = 5'h00;
  localparam logic [7:0]  SCRATCH_RESET = 8'h00;

  // Cycle counts of the 16x bit timing
  localparam logic [3:0] TICKS_LAST   = 4'hf; // 16 ticks per bit
  localparam logic [3:0] TICKS_MID    = 4'h7; // middle of the start bit
  localparam logic [2:0] DATA_LAST    = 3'h7; // 8 data bits

  // Receive trigger levels for fifo mode
  localparam logic [4:0] TRIG_1  = 5'h01;
  localparam logic [4:0] TRIG_4  = 5'h04;
  localparam logic [4:0] TRIG_8  = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0e;

  // Modem lines as seen by software, active high
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_lines_type;

  // Modem control outputs
  typedef struct packed {
    logic user_output_two;
    logic user_output_one;
    logic rts;
    logic dtr;
  } modem_ctrl_type;

  typedef enum logic [3:0] {
    rx_idle  = 4'b0001,
    rx_start = 4'b0010,
    rx_data  = 4'b0100,
    rx_stop  = 4'b1000
  } rx_state_type;

  typedef enum logic [3:0] {
    tx_idle  = 4'b0001,
    tx_start = 4'b0010,
    tx_data  = 4'b0100,
    tx_stop  = 4'b1000
  } tx_state_type;
endpackage
`default_nettype wire

// ==== core/uart_core.sv ====
// Behaviour
// - Set trailing ring edge bit 2 when ring input rises low to high.
// - Set carrier change bit 3 when carrier input changed since last status read.
// - Either bit with modem interrupt enabled raises the modem status interrupt.
// - Bit 4 is inverted clear-to-send; in loopback it follows request-to-send control.
// - Bit 5 is inverted data-set-ready; in loopback it follows terminal-ready control.
// - Bit 6 is inverted ring input; in loopback it follows user output one.
// - Bit 7 is inverted carrier input; in loopback it follows user output two.
// - Baud generator divides input clock by divisor from 1 to 65535.
// - Baud output runs at sixteen times the wanted baud rate.
// - Two 8-bit divisor latches form one 16-bit divisor.
// - Writing either divisor latch reloads the baud counter at once.
// - Receive shifter samples on 16x ticks and fills a 16-byte buffer.
// - Character mode: data available interrupt while data held, cleared by reading.
// - 8-bit scratch register reads back what was written, nothing else.
// - Bus writes fill 16-byte transmit buffer; idle shifter takes and serializes.
// - Transmitter is timed by the baud generator ticks.
// - Character mode: holding-empty interrupt while empty, cleared by a write.
// - Fifo mode: receive interrupt follows the fifo control trigger level; holding-empty interrupt is unchanged.
// - Reading modem status clears the change bits that the read returned; bits set since the read data was captured stay set.
// - Control bit 4 selects loopback: modem inputs cut, controls looped back.
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uart_core
  import uart_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic            clk_en,
  input  wire logic [5:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  output var  logic [31:0]     avs_readdata,
  output var  logic            avs_waitrequest,
  input  wire logic            serial_input,
  input  wire modem_lines_type modem_in_n,
  output var  logic            serial_output,
  output var  modem_ctrl_type  modem_out_n,
  output var  logic            baud_tick_output,
  output var  logic            irq
);
  localparam int PW = $clog2(DEPTH);

  // Pointer advance with wrap, shared by both buffers
  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  logic [3:0]      int_en;
  logic [7:0]      fifo_ctl;
  logic [4:0]      mlc;
  logic [7:0]      scratchpad;
  logic [7:0]      baud_divisor_low;
  logic [7:0]      baud_divisor_high;
  logic [3:0]      mls_delta;
  logic            overrun;
  logic [4:0]      sync1;
  logic [4:0]      sync2;
  logic [4:0]      sync3;
  logic [4:0]      filt;
  logic [4:0]      pins;
  modem_lines_type live;
  modem_lines_type prev_live;
  logic [7:0]      mls_value;
  logic [3:0]      delta_set;
  logic            loop;
  logic            req;
  logic            done;
  logic            wr_done;
  logic            rd_done;
  logic [7:0]      wbyte;
  logic [15:0]     baud_count;
  logic            baud_tick;
  logic [7:0]      rx_mem [DEPTH];
  logic [PW-1:0]   rx_wr;
  logic [PW-1:0]   rx_rd;
  logic [PW:0]     rx_count;
  logic [7:0]      tx_mem [DEPTH];
  logic [PW-1:0]   tx_wr;
  logic [PW-1:0]   tx_rd;
  logic [PW:0]     tx_count;
  logic [PW:0]     capacity;
  logic [4:0]      trigger;
  logic            rx_push;
  logic            rx_pop;
  logic            tx_push;
  logic            tx_pop;
  logic            rx_clear;
  logic            tx_clear;
  rx_state_type    rx_state;
  logic [3:0]      rx_ticks;
  logic [2:0]      rx_bits;
  logic [7:0]      rx_shift;
  logic            rx_in;
  tx_state_type    tx_state;
  logic [3:0]      tx_ticks;
  logic [2:0]      tx_bits;
  logic [7:0]      tx_shift;
  logic            tx_line;
  logic [2:0]      pending;
  logic [7:0]      lsr_value;

  // Serial pin on top of the four modem pins
  assign pins = {serial_input, modem_in_n};

  // Pin synchronisers; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
          sync3[gi] <= 1'b1;
          filt[gi]  <= 1'b1;
        end else if (clk_en) begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            filt[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  // Live modem lines, inputs complemented or control bits looped back
  assign loop     = mlc[MC_LOOP_POS];
  assign live.cts = loop ? mlc[1] : ~filt[0];
  assign live.dsr = loop ? mlc[0] : ~filt[1];
  assign live.ri  = loop ? mlc[2] : ~filt[2];
  assign live.dcd = loop ? mlc[3] : ~filt[3];
  assign rx_in    = loop ? tx_line : filt[4];

  // Change detection; ring trailing edge is the pin going low to high
  assign delta_set[0] = live.cts ^ prev_live.cts;
  assign delta_set[1] = live.dsr ^ prev_live.dsr;
  assign delta_set[2] = prev_live.ri & ~live.ri;
  assign delta_set[3] = live.dcd ^ prev_live.dcd;
  assign mls_value    = {live, mls_delta};

  // Bus handshake: answer one cycle after the request is seen
  assign req     = avs_read | avs_write;
  assign done    = clk_en & req & ~avs_waitrequest;
  assign wr_done = done & avs_write;
  assign rd_done = done & avs_read;
  assign wbyte   = avs_writedata[7:0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= ~(req & avs_waitrequest);
    end
  end

  // Line status word
  always_comb begin
    lsr_value = 8'h00;
    lsr_value[LS_READY_POS]   = (rx_count != '0);
    lsr_value[LS_OVERRUN_POS] = overrun;
    lsr_value[LS_HOLD_POS]    = (tx_count == '0);
    lsr_value[LS_TEMT_POS]    = (tx_count == '0) && (tx_state == tx_idle);
  end

  // Read data captured in the cycle before the answer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en && avs_read && avs_waitrequest) begin
      avs_readdata <= 32'h0000_0000;
      case (avs_address)
        OFS_DATA:     avs_readdata[7:0] <= (rx_count != '0) ? rx_mem[rx_rd] : 8'h00;
        OFS_INT_EN:   avs_readdata[3:0] <= int_en;
        OFS_INT_PEND: avs_readdata[2:0] <= pending;
        OFS_FIFO_CTL: avs_readdata[7:0] <= fifo_ctl;
        OFS_MLC:      avs_readdata[4:0] <= mlc;
        OFS_LSR:      avs_readdata[7:0] <= lsr_value;
        OFS_MLS:      avs_readdata[7:0] <= mls_value;
        OFS_SCRATCH:  avs_readdata[7:0] <= scratchpad;
        OFS_DIV_LO:   avs_readdata[7:0] <= baud_divisor_low;
        OFS_DIV_HI:   avs_readdata[7:0] <= baud_divisor_high;
        default:      avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Software written control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_en            <= INT_EN_RESET;
      fifo_ctl          <= FIFO_CTL_RESET;
      mlc               <= MLC_RESET;
      scratchpad        <= SCRATCH_RESET;
      baud_divisor_low  <= DIV_LO_RESET;
      baud_divisor_high <= DIV_HI_RESET;
    end else if (wr_done) begin
      case (avs_address)
        OFS_INT_EN:   int_en <= wbyte[3:0];
        OFS_FIFO_CTL: fifo_ctl <= {wbyte[7:6], 5'h00, wbyte[0]};
        OFS_MLC:      mlc <= wbyte[4:0];
        OFS_SCRATCH:  scratchpad <= wbyte;
        OFS_DIV_LO:   baud_divisor_low <= wbyte;
        OFS_DIV_HI:   baud_divisor_high <= wbyte;
        default:      ;
      endcase
    end
  end

  // Modem change bits; a new change wins over the read clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_live <= '0;
      mls_delta <= 4'h0;
    end else if (clk_en) begin
      prev_live <= live;
      if (rd_done && avs_address == OFS_MLS) begin
        mls_delta <= (mls_delta & ~avs_readdata[3:0]) | delta_set;
      end else begin
        mls_delta <= mls_delta | delta_set;
      end
    end
  end

  // Baud counter: down count, tick and reload; divisor writes reload at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      baud_count <= {DIV_HI_RESET, DIV_LO_RESET};
      baud_tick  <= 1'b0;
    end else if (clk_en) begin
      baud_tick <= 1'b0;
      if (wr_done && avs_address == OFS_DIV_LO) begin
        baud_count <= {baud_divisor_high, wbyte};
      end else if (wr_done && avs_address == OFS_DIV_HI) begin
        baud_count <= {wbyte, baud_divisor_low};
      end else if (baud_count <= 16'h0001) begin
        baud_count <= {baud_divisor_high, baud_divisor_low};
        baud_tick  <= 1'b1;
      end else begin
        baud_count <= baud_count - 16'h0001;
      end
    end
  end
  assign baud_tick_output = baud_tick;

  // Buffer depth: one word in character mode, full depth in fifo mode
  assign capacity = fifo_ctl[FC_MODE_POS] ? (PW+1)'(DEPTH) : (PW+1)'(1);
  assign rx_clear = wr_done && avs_address == OFS_FIFO_CTL &&
                    (wbyte[FC_RXCLR_POS] || wbyte[FC_MODE_POS] != fifo_ctl[FC_MODE_POS]);
  assign tx_clear = wr_done && avs_address == OFS_FIFO_CTL &&
                    (wbyte[FC_TXCLR_POS] || wbyte[FC_MODE_POS] != fifo_ctl[FC_MODE_POS]);
  assign rx_pop   = rd_done && avs_address == OFS_DATA && rx_count != '0;
  assign tx_push  = wr_done && avs_address == OFS_DATA && tx_count < capacity;
  assign tx_pop   = clk_en && tx_state == tx_idle && tx_count != '0;

  // Receive buffer storage and pointers
  always_ff @(posedge clk) begin
    if (rx_push) begin
      rx_mem[rx_wr] <= rx_shift;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_wr    <= '0;
      rx_rd    <= '0;
      rx_count <= '0;
    end else if (rx_clear) begin
      rx_wr    <= '0;
      rx_rd    <= '0;
      rx_count <= '0;
    end else begin
      if (rx_push) begin
        rx_wr <= next_ptr(rx_wr);
      end
      if (rx_pop) begin
        rx_rd <= next_ptr(rx_rd);
      end
      rx_count <= rx_count + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
    end
  end

  // Transmit buffer storage and pointers
  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wr] <= wbyte;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_wr    <= '0;
      tx_rd    <= '0;
      tx_count <= '0;
    end else if (tx_clear) begin
      tx_wr    <= '0;
      tx_rd    <= '0;
      tx_count <= '0;
    end else begin
      if (tx_push) begin
        tx_wr <= next_ptr(tx_wr);
      end
      if (tx_pop) begin
        tx_rd <= next_ptr(tx_rd);
      end
      tx_count <= tx_count + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
    end
  end

  // Receiver, fixed 8 data bits and one stop bit, sampled on 16x ticks
  assign rx_push = clk_en && baud_tick && rx_state == rx_stop &&
                   rx_ticks == TICKS_LAST && rx_count < capacity;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state <= rx_idle;
      rx_ticks <= 4'h0;
      rx_bits  <= 3'h0;
      rx_shift <= 8'h00;
    end else if (clk_en) begin
      case (rx_state)
        rx_idle: begin
          rx_ticks <= 4'h0;
          if (!rx_in) begin
            rx_state <= rx_start;
          end
        end
        rx_start: begin
          if (baud_tick) begin
            rx_ticks <= rx_ticks + 4'h1;
            if (rx_ticks == TICKS_MID) begin
              rx_ticks <= 4'h0;
              rx_bits  <= 3'h0;
              rx_state <= rx_in ? rx_idle : rx_data;   // False start rejected
            end
          end
        end
        rx_data: begin
          if (baud_tick) begin
            rx_ticks <= rx_ticks + 4'h1;
            if (rx_ticks == TICKS_LAST) begin
              rx_shift <= {rx_in, rx_shift[7:1]};
              rx_bits  <= rx_bits + 3'h1;
              if (rx_bits == DATA_LAST) begin
                rx_state <= rx_stop;
              end
            end
          end
        end
        rx_stop: begin
          if (baud_tick) begin
            rx_ticks <= rx_ticks + 4'h1;
            if (rx_ticks == TICKS_LAST) begin
              rx_state <= rx_idle;
            end
          end
        end
        default: rx_state <= rx_idle;
      endcase
    end
  end

  // Overrun: a character arriving at a full buffer is dropped and flagged
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overrun <= 1'b0;
    end else if (clk_en) begin
      if (baud_tick && rx_state == rx_stop && rx_ticks == TICKS_LAST && rx_count >= capacity) begin
        overrun <= 1'b1;
      end else if (rd_done && avs_address == OFS_LSR) begin
        overrun <= 1'b0;
      end
    end
  end

  // Transmitter: start, 8 data bits, stop, each 16 baud ticks long
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state <= tx_idle;
      tx_ticks <= 4'h0;
      tx_bits  <= 3'h0;
      tx_shift <= 8'h00;
      tx_line  <= 1'b1;
    end else if (clk_en) begin
      case (tx_state)
        tx_idle: begin
          tx_ticks <= 4'h0;
          if (tx_pop) begin
            tx_shift <= tx_mem[tx_rd];
            tx_line  <= 1'b0;
            tx_state <= tx_start;
          end
        end
        tx_start: begin
          if (baud_tick) begin
            tx_ticks <= tx_ticks + 4'h1;
            if (tx_ticks == TICKS_LAST) begin
              tx_line  <= tx_shift[0];
              tx_bits  <= 3'h0;
              tx_state <= tx_data;
            end
          end
        end
        tx_data: begin
          if (baud_tick) begin
            tx_ticks <= tx_ticks + 4'h1;
            if (tx_ticks == TICKS_LAST) begin
              tx_shift <= {1'b0, tx_shift[7:1]};
              tx_bits  <= tx_bits + 3'h1;
              tx_line  <= (tx_bits == DATA_LAST) ? 1'b1 : tx_shift[1];
              if (tx_bits == DATA_LAST) begin
                tx_state <= tx_stop;
              end
            end
          end
        end
        tx_stop: begin
          if (baud_tick) begin
            tx_ticks <= tx_ticks + 4'h1;
            if (tx_ticks == TICKS_LAST) begin
              tx_state <= tx_idle;
            end
          end
        end
        default: tx_state <= tx_idle;
      endcase
    end
  end

  // Receive trigger level in fifo mode
  always_comb begin
    case (fifo_ctl[7:6])
      2'b00:   trigger = TRIG_1;
      2'b01:   trigger = TRIG_4;
      2'b10:   trigger = TRIG_8;
      default: trigger = TRIG_14;
    endcase
  end

  // Interrupt causes: receive, holding empty, modem status
  always_comb begin
    if (fifo_ctl[FC_MODE_POS]) begin
      pending[0] = int_en[IE_RX_POS] && 5'(rx_count) >= trigger;
    end else begin
      pending[0] = int_en[IE_RX_POS] && rx_count != '0;
    end
    pending[1] = int_en[IE_HOLD_POS] && tx_count == '0;
    pending[2] = int_en[IE_MODEM_POS] && mls_delta != 4'h0;
  end

  // Registered pin outputs; loopback holds the serial and modem outputs inactive high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq           <= 1'b0;
      serial_output <= 1'b1;
      modem_out_n   <= '1;
    end else if (clk_en) begin
      irq           <= |pending;
      serial_output <= loop | tx_line;
      modem_out_n   <= loop ? '1 : ~mlc[3:0];
    end
  end
endmodule
`default_nettype wire

// ==== bench/uart_core_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module uart_core_props
  import uart_pkg::*;
(
  input wire logic            clk,
  input wire logic            reset_n,
  input wire logic [5:0]      avs_address,
  input wire logic            avs_read,
  input wire logic            avs_write,
  input wire logic [31:0]     avs_writedata,
  input wire logic [31:0]     avs_readdata,
  input wire logic            avs_waitrequest,
  input wire modem_lines_type modem_in_n,
  input wire logic            serial_output,
  input wire modem_ctrl_type  modem_out_n,
  input wire logic            baud_tick_output
);
  logic        wr;
  logic        rd;
  logic [7:0]  sc;
  logic [7:0]  dlo;
  logic [7:0]  dhi;
  logic [4:0]  mlc;
  logic [16:0] gap;
  logic        gap_ok;
  logic [3:0]  quiet;
  logic        seen;
  logic [16:0] div;
  // Completed bus cycles and the divisor in force (0 acts as 1)
  assign wr = avs_write && !avs_waitrequest;
  assign rd = avs_read && !avs_waitrequest;
  assign div = ({dhi, dlo} == 16'h0000) ? 17'h00001 : {1'b0, dhi, dlo};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Shadow copies of the written registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sc <= SCRATCH_RESET;
      dlo <= DIV_LO_RESET;
      dhi <= DIV_HI_RESET;
      mlc <= MLC_RESET;
    end else if (wr) begin
      if (avs_address == OFS_SCRATCH) sc <= avs_writedata[7:0];
      if (avs_address == OFS_DIV_LO) dlo <= avs_writedata[7:0];
      if (avs_address == OFS_DIV_HI) dhi <= avs_writedata[7:0];
      if (avs_address == OFS_MLC) mlc <= avs_writedata[4:0];
    end
  end
  // Tick spacing is trusted only between two ticks with no divisor write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap <= 17'h00000;
      gap_ok <= 1'b0;
    end else begin
      gap <= baud_tick_output ? 17'h00001 : gap + 17'h00001;
      if (wr && (avs_address == OFS_DIV_LO || avs_address == OFS_DIV_HI)) gap_ok <= 1'b0;
      else if (baud_tick_output) gap_ok <= 1'b1;
    end
  end
  // Settling time since a modem change, and a clean status read since then
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet <= 4'h0;
      seen <= 1'b0;
    end else if (modem_in_n != $past(modem_in_n) || (wr && avs_address == OFS_MLC)) begin
      quiet <= 4'h0;
      seen <= 1'b0;
    end else begin
      if (quiet != 4'hf) quiet <= quiet + 4'h1;
      if (rd && avs_address == OFS_MLS && quiet >= 4'h8) seen <= 1'b1;
    end
  end
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop one cycle after a request");
  a_tick_spacing: assert property (baud_tick_output && gap_ok |-> gap == div)
    else $error("baud tick spacing differs from divisor");
  a_scratch_echo: assert property (rd && avs_address == OFS_SCRATCH |-> avs_readdata == {24'h0, sc})
    else $error("scratch read differs from last write");
  a_divisor_echo: assert property (rd && (avs_address == OFS_DIV_LO || avs_address == OFS_DIV_HI)
    |-> avs_readdata[7:0] == ((avs_address == OFS_DIV_LO) ? dlo : dhi))
    else $error("divisor read differs from last write");
  a_status_live: assert property (rd && avs_address == OFS_MLS && !mlc[MC_LOOP_POS] && quiet >= 4'h8
    |-> avs_readdata[7:4] == ~modem_in_n)
    else $error("modem status levels differ from inverted inputs");
  a_status_loop: assert property (rd && avs_address == OFS_MLS && mlc[MC_LOOP_POS] && quiet >= 4'h8
    |-> avs_readdata[7:4] == {mlc[3], mlc[2], mlc[0], mlc[1]})
    else $error("loopback status levels differ from control bits");
  a_loop_outputs: assert property (mlc[MC_LOOP_POS] && quiet >= 4'h2
    |-> serial_output && modem_out_n == 4'hf)
    else $error("outputs not inactive in loopback");
  a_change_clear: assert property (rd && avs_address == OFS_MLS && seen && quiet >= 4'h8
    |-> avs_readdata[3:0] == 4'h0)
    else $error("change bits not cleared by status read");
  c_tick: cover property (baud_tick_output && gap_ok && gap > 17'h00002);
  c_loop_read: cover property (rd && avs_address == OFS_MLS && mlc[MC_LOOP_POS]);
  c_clear_read: cover property (rd && avs_address == OFS_MLS && seen);
endmodule
bind uart_core uart_core_props u_props (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .modem_in_n, .serial_output, .modem_out_n,
  .baud_tick_output);
`default_nettype wire

// ==== bench/modem_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module modem_peer
  import uart_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            serial_output,
  output var  logic            serial_input,
  output var  modem_lines_type modem_in_n
);
  // Line idles at mark, modem lines inactive
  initial begin
    serial_input = 1'b1;
    modem_in_n = 4'hf;
  end
  // One 8N1 frame, LSB first, cyc clocks per bit
  task automatic send(input logic [7:0] b, input int cyc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_input <= f[i];
      repeat (cyc) @(posedge clk);
    end
  endtask
  // Catch one frame from the block, sampling in mid bit
  task automatic catch(input int cyc, output logic [7:0] b);
    while (serial_output !== 1'b0) @(negedge clk);
    repeat (cyc / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (cyc) @(negedge clk);
      b[i] = serial_output;
    end
  endtask
endmodule
`default_nettype wire

// ==== bench/test_uart_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_uart_core
  import uart_pkg::*;
();
  logic            clk = 1'b0;
  logic            reset_n = 1'b0;
  logic [5:0]      avs_address = 6'h00;
  logic            avs_read = 1'b0;
  logic            avs_write = 1'b0;
  logic [31:0]     avs_writedata = 32'h0;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest;
  logic            serial_input;
  logic            serial_output;
  logic            baud_tick_output;
  logic            irq;
  modem_lines_type modem_in_n;
  modem_ctrl_type  modem_out_n;
  logic [31:0]     q;
  logic [7:0]      b;
  int              g;
  int              n_mismatch = 0;
  int              compares = 0;
  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end
  uart_core #(.DEPTH(16)) DUT (.clk, .reset_n, .clk_en(1'b1), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .serial_input,
    .modem_in_n, .serial_output, .modem_out_n, .baud_tick_output, .irq);
  modem_peer peer (.clk, .serial_output, .serial_input, .modem_in_n);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= {24'h0, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic tick_gap();
    g = 0;
    @(negedge clk);
    while (baud_tick_output !== 1'b1) @(negedge clk);
    do begin
      @(negedge clk);
      g++;
    end while (baud_tick_output !== 1'b1);
  endtask
  task automatic t_regs();
    rd(OFS_DIV_LO);
    chk("div_lo reset", {24'h0, DIV_LO_RESET}, q);
    wr(OFS_SCRATCH, 8'ha5);
    rd(OFS_SCRATCH);
    chk("scratch", 32'h000000a5, q);
    rd(6'h3c);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_baud();
    wr(OFS_DIV_LO, 8'h03);
    tick_gap();
    chk("tick gap 3", 32'd3, 32'(g));
    wr(OFS_DIV_HI, 8'h01);
    tick_gap();
    chk("tick gap 259", 32'd259, 32'(g));
    wr(OFS_DIV_HI, 8'h00);
    wr(OFS_DIV_LO, 8'h02);
  endtask
  task automatic t_modem();
    rd(OFS_MLS);
    peer.modem_in_n <= 4'b1010;
    repeat (8) @(posedge clk);
    rd(OFS_MLS);
    chk("status lines", 32'h51, q);
    wr(OFS_INT_EN, 8'h08);
    peer.modem_in_n <= 4'b0110;
    repeat (8) @(negedge clk);
    chk("irq modem", 32'h1, {31'h0, irq});
    rd(OFS_MLS);
    chk("ring and carrier", 32'h9c, q);
    repeat (3) @(negedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(OFS_MLS);
    chk("changes cleared", 32'h90, q);
    wr(OFS_INT_EN, 8'h00);
  endtask
  task automatic t_serial();
    wr(OFS_DATA, 8'h96);
    peer.catch(32, b);
    chk("tx byte", 32'h96, {24'h0, b});
    wr(OFS_INT_EN, 8'h01);
    peer.send(8'h3c, 32);
    repeat (40) @(negedge clk);
    chk("irq rx", 32'h1, {31'h0, irq});
    rd(OFS_DATA);
    chk("rx byte", 32'h3c, q);
    repeat (3) @(negedge clk);
    chk("irq rx read", 32'h0, {31'h0, irq});
    wr(OFS_INT_EN, 8'h00);
  endtask
  task automatic t_loop();
    wr(OFS_MLC, 8'h15);
    repeat (8) @(negedge clk);
    chk("loop outputs", 32'h1f, {27'h0, serial_output, modem_out_n});
    rd(OFS_MLS);
    chk("loop lines", 32'h6, {28'h0, q[7:4]});
    wr(OFS_FIFO_CTL, 8'h01);
    for (int i = 1; i <= 3; i++) wr(OFS_DATA, 8'(i * 17));
    repeat (1100) @(posedge clk);
    for (int i = 1; i <= 3; i++) begin
      rd(OFS_DATA);
      chk("loop byte", 32'(i * 17), q);
    end
    wr(OFS_INT_EN, 8'h02);
    repeat (3) @(negedge clk);
    chk("irq empty", 32'h1, {31'h0, irq});
    wr(OFS_INT_EN, 8'h00);
    wr(OFS_MLC, 8'h00);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_baud();
    t_modem();
    t_serial();
    t_loop();
    tally_and_finish();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
